/* File: design/avionics_serial_host_port_defs.vh */
// Constants for the avionics serial host port: option layout, resets, rates and timing
`ifndef AVIONICS_SERIAL_HOST_PORT_DEFS_VH
`define AVIONICS_SERIAL_HOST_PORT_DEFS_VH

// ****************************************************************
// Option word: bus bits 5..14 land in option bits 0..9
// ****************************************************************
`define OPT_BUS_LSB 5
`define OPT_BUS_MSB 14
`define OPT_WIDTH 10
`define OPT_LOOPBACK_SELECT_N 0
`define OPT_RX1_LABEL_FILTER_EN 1
`define OPT_RX1_MATCH_BIT9 2
`define OPT_RX1_MATCH_BIT10 3
`define OPT_RX2_LABEL_FILTER_EN 4
`define OPT_RX2_MATCH_BIT9 5
`define OPT_RX2_MATCH_BIT10 6
`define OPT_PARITY_INVERT 7
`define OPT_TX_RATE_SELECT 8
`define OPT_RX_RATE_SELECT 9
// Reset value: loopback off, filters off, odd parity, fast rates
`define OPT_RESET 10'h001

// ****************************************************************
// Rate division and timing counts, in master clocks, bit times or half-bit times
// ****************************************************************
`define DIV_FAST 7'h0a
`define DIV_SLOW 7'h50
`define DIV_WIDTH 7
`define TX_GAP_HALF_BITS 3'h7
`define RX_GAP_TICKS 2'h2
`define WORD_BITS 32
`define TX_DATA_BITS 31
`define TX_LAST_BIT 5'h1e
`define RX_LAST_BIT 5'h1f

`endif

/* File: design/sync_word_fifo.v */
// Synchronous word FIFO with valid/ready on both sides and a soft clear
`timescale 1ns/1ps
module sync_word_fifo #(
  parameter WIDTH = 31,
  parameter DEPTH = 4
) (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_clear,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest flags from the occupancy count
  assign o_in_ready = (count_q != DEPTH[AW:0]);
  assign o_out_valid = (count_q != {(AW+1){1'b0}});
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_q[rd_ptr_q[AW-1:0]];

  // Pointers wrap at DEPTH so any depth works, not only powers of two
  always @(posedge i_mclk) begin
    if (i_sys_rst || (i_clk_en && i_clear)) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else if (i_clk_en) begin
      if (push) begin
        mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // sync_word_fifo

/* File: design/rx_word_assembler.v */
// One receiver: classifies line states and shifts in 32-bit words
`timescale 1ns/1ps
`include "avionics_serial_host_port_defs.vh"
module rx_word_assembler (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_clear,
  input wire i_rx_tick,
  input wire i_line_one,
  input wire i_line_zero,
  output reg [`WORD_BITS-1:0] o_word,
  output reg o_word_complete_event
);
  reg [`WORD_BITS-1:0] shift_q;
  reg [4:0] bit_cnt_q;
  reg was_null_q;
  reg bad_q;
  reg [1:0] null_ticks_q;
  wire is_null;
  wire is_bad;
  wire new_bit;
  wire [`WORD_BITS-1:0] shift_d;

  assign is_null = ~i_line_one & ~i_line_zero;
  assign is_bad = i_line_one & i_line_zero;
  assign new_bit = was_null_q & ~is_null & ~is_bad;
  // First bit in ends up in bit 0
  assign shift_d = {i_line_one, shift_q[`WORD_BITS-1:1]};

  // Bit shifting, word gap detection and rejection of bad states
  always @(posedge i_mclk) begin
    if (i_sys_rst || (i_clk_en && i_clear)) begin
      shift_q <= {`WORD_BITS{1'b0}};
      bit_cnt_q <= 5'h00;
      was_null_q <= 1'b0;
      bad_q <= 1'b0;
      null_ticks_q <= 2'h0;
      o_word <= {`WORD_BITS{1'b0}};
      o_word_complete_event <= 1'b0;
    end else if (i_clk_en) begin
      o_word_complete_event <= 1'b0;
      was_null_q <= is_null;
      if (!is_null) begin
        null_ticks_q <= 2'h0;
      end else if (i_rx_tick && null_ticks_q != `RX_GAP_TICKS) begin
        null_ticks_q <= null_ticks_q + 2'h1;
      end
      if (is_bad) begin
        bad_q <= 1'b1;
        bit_cnt_q <= 5'h00;
      end else if (is_null && null_ticks_q == `RX_GAP_TICKS) begin
        // A long null is a word gap: restart framing and forgive errors
        bad_q <= 1'b0;
        bit_cnt_q <= 5'h00;
      end else if (new_bit && !bad_q) begin
        shift_q <= shift_d;
        if (bit_cnt_q == `RX_LAST_BIT) begin
          bit_cnt_q <= 5'h00;
          // Bit 32 turns into a parity error flag
          o_word <= {~(^shift_d), shift_d[`WORD_BITS-2:0]};
          o_word_complete_event <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end
endmodule // rx_word_assembler

/* File: design/avionics_serial_host_port.v */
// Host-side parallel interface of a two-receiver, one-transmitter serial transceiver
`timescale 1ns/1ps
`include "avionics_serial_host_port_defs.vh"

// Overview of operation
// - byte_select low gives byte 1, high byte 2
// - receiver 1 wins; receiver 2 only if 1 idle
// - byte1 load strobe captures first transmit byte
// - fifo idle low on load, high when drained
// - separate ones and zeros pulse outputs
// - bit clock out is master clock /10 or /80
// - master_reset_n is an active-low reset
// - ten option bits loaded from bus 5..14
// - option bit 5 low loops transmitter to receivers
// - receiver 1 label filter on bits 9, 10
// - receiver 2 label filter on bits 9, 10
// - option bit 12 picks odd or even parity
// - option bit 13 picks transmit divisor
// - option bit 14 picks receive divisor
// - serial bit 1 goes first both ways
// - byte 1 bus mapping of serial bits
// - receivers discard words with bad line states
// - loopback: receiver 2 sees the complement
// - ready only if filter off or matched
// - ready stays low until both bytes read
// - master reset clears FIFO, transmitter and receivers; option word, byte 1 and rate counters are kept
module avionics_serial_host_port #(
  parameter TX_FIFO_DEPTH = 4
) (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_clk_en,
  input wire i_master_reset_n,
  input wire [15:0] i_bus_in,
  output reg [15:0] o_bus_out,
  output wire o_bus_oe,
  input wire i_byte_select,
  input wire i_rx1_read_enable_n,
  input wire i_rx2_read_enable_n,
  input wire i_tx_byte1_load_n,
  input wire i_tx_byte2_load_n,
  input wire i_option_word_strobe,
  input wire i_tx_enable_transmit,
  input wire i_rx1_line_one,
  input wire i_rx1_line_zero,
  input wire i_rx2_line_one,
  input wire i_rx2_line_zero,
  output wire o_rx1_word_ready_n,
  output wire o_rx2_word_ready_n,
  output wire o_tx_fifo_idle,
  output wire o_tx_fifo_full,
  output wire o_tx_line_outputs_one,
  output wire o_tx_line_outputs_zero,
  output reg o_tx_bit_clock_out
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam ST_IDLE = 5'b00001;
  localparam ST_SYNC = 5'b00010;
  localparam ST_HIGH = 5'b00100;
  localparam ST_NULL = 5'b01000;
  localparam ST_GAP = 5'b10000;

  reg [`OPT_WIDTH-1:0] option_latch_word_q;
  reg strobe_q;
  reg load1_n_q;
  reg load2_n_q;
  reg [15:0] tx_byte1_q;
  reg [`DIV_WIDTH-1:0] tx_div_cnt_q;
  reg [`DIV_WIDTH-1:0] rx_div_cnt_q;
  reg [4:0] tx_state_q;
  reg [`WORD_BITS-1:0] tx_shift_q;
  reg [4:0] tx_bit_cnt_q;
  reg [2:0] tx_gap_cnt_q;
  reg tx_in_gap_q;
  reg [1:0] ready_q;
  reg [1:0] byte1_read_q;
  reg [1:0] byte2_read_q;
  wire soft_clear;
  wire [`DIV_WIDTH-1:0] tx_div;
  wire [`DIV_WIDTH-1:0] rx_div;
  wire tx_half_tick;
  wire rx_tick;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_pop;
  wire [`TX_DATA_BITS-1:0] fifo_out_data;
  wire [`TX_DATA_BITS-1:0] tx_word;
  wire tx_parity;
  wire [1:0] line_one;
  wire [1:0] line_zero;
  wire [1:0] word_event;
  wire [1:0] accept;
  wire [1:0] read_on;
  wire [2*`WORD_BITS-1:0] rx_words;
  wire [`WORD_BITS-1:0] rd_word;

  assign soft_clear = ~i_master_reset_n;

  // ****************************************************************
  // Option word
  // ****************************************************************
  // latch bus 5..14 on strobe rise
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      option_latch_word_q <= `OPT_RESET;
      strobe_q <= 1'b0;
    end else if (i_clk_en) begin
      strobe_q <= i_option_word_strobe;
      if (i_option_word_strobe && !strobe_q) begin
        option_latch_word_q <= i_bus_in[`OPT_BUS_MSB:`OPT_BUS_LSB];
      end
    end
  end

  // ****************************************************************
  // Rate dividers
  // ****************************************************************
  // transmit divisor select
  assign tx_div = option_latch_word_q[`OPT_TX_RATE_SELECT] ? `DIV_SLOW : `DIV_FAST;
  assign rx_div = option_latch_word_q[`OPT_RX_RATE_SELECT] ? `DIV_SLOW : `DIV_FAST;
  assign tx_half_tick = (tx_div_cnt_q == tx_div - 1'b1) || (tx_div_cnt_q == (tx_div >> 1) - 1'b1);
  assign rx_tick = (rx_div_cnt_q == rx_div - 1'b1);

  // bit clock high in first half
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tx_div_cnt_q <= {`DIV_WIDTH{1'b0}};
      rx_div_cnt_q <= {`DIV_WIDTH{1'b0}};
      o_tx_bit_clock_out <= 1'b0;
    end else if (i_clk_en) begin
      // Wrap with >= so a rate change mid-period cannot overrun
      tx_div_cnt_q <= (tx_div_cnt_q >= tx_div - 1'b1) ? {`DIV_WIDTH{1'b0}} : tx_div_cnt_q + 1'b1;
      rx_div_cnt_q <= (rx_div_cnt_q >= rx_div - 1'b1) ? {`DIV_WIDTH{1'b0}} : rx_div_cnt_q + 1'b1;
      o_tx_bit_clock_out <= (tx_div_cnt_q + 1'b1 < (tx_div >> 1)) || (tx_div_cnt_q >= tx_div - 1'b1);
    end
  end

  // ****************************************************************
  // Transmit byte loading
  // ****************************************************************
  // byte 1 captured on falling strobe
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      load1_n_q <= 1'b1;
      load2_n_q <= 1'b1;
      tx_byte1_q <= 16'h0000;
    end else if (i_clk_en) begin
      load1_n_q <= i_tx_byte1_load_n;
      load2_n_q <= i_tx_byte2_load_n;
      if (!i_tx_byte1_load_n && load1_n_q) begin
        tx_byte1_q <= i_bus_in;
      end
    end
  end

  // unpack byte 1; bus bit 8 (slot of bit 32) is stored but unused
  // byte 2 bus 15..0 holds bits 14..29
  // byte 2 strobe completes the word
  assign tx_word = {tx_byte1_q[10], tx_byte1_q[9], i_bus_in[0], i_bus_in[1], i_bus_in[2],
                    i_bus_in[3], i_bus_in[4], i_bus_in[5], i_bus_in[6], i_bus_in[7],
                    i_bus_in[8], i_bus_in[9], i_bus_in[10], i_bus_in[11], i_bus_in[12],
                    i_bus_in[13], i_bus_in[14], i_bus_in[15], tx_byte1_q[15:11],
                    tx_byte1_q[0], tx_byte1_q[1], tx_byte1_q[2], tx_byte1_q[3],
                    tx_byte1_q[4], tx_byte1_q[5], tx_byte1_q[6], tx_byte1_q[7]};

  // Words loaded while full are dropped
  sync_word_fifo #(
    .WIDTH(`TX_DATA_BITS),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_clear(soft_clear),
    .i_in_valid(!i_tx_byte2_load_n && load2_n_q),
    .o_in_ready(fifo_in_ready),
    .i_in_data(tx_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );
  assign o_tx_fifo_full = ~fifo_in_ready;

  // ****************************************************************
  // Transmit sequencer
  // ****************************************************************
  // odd parity when clear, even when set
  assign tx_parity = (^fifo_out_data) ^ ~option_latch_word_q[`OPT_PARITY_INVERT];
  assign fifo_pop = (tx_state_q == ST_IDLE) & i_tx_enable_transmit & fifo_out_valid;

  // bit 1 first; half-bit pulse, half-bit null
  always @(posedge i_mclk) begin
    if (i_sys_rst || (i_clk_en && soft_clear)) begin
      tx_state_q <= ST_IDLE;
      tx_shift_q <= {`WORD_BITS{1'b0}};
      tx_bit_cnt_q <= 5'h00;
      tx_gap_cnt_q <= 3'h0;
      tx_in_gap_q <= 1'b0;
    end else if (i_clk_en) begin
      case (tx_state_q)
        ST_IDLE: begin
          tx_in_gap_q <= 1'b0;
          if (fifo_pop) begin
            tx_shift_q <= {tx_parity, fifo_out_data};
            tx_bit_cnt_q <= 5'h00;
            tx_state_q <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (tx_half_tick) begin
            tx_state_q <= tx_in_gap_q ? ST_IDLE : ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tx_half_tick) begin
            tx_state_q <= ST_NULL;
          end
        end
        ST_NULL: begin
          if (tx_half_tick) begin
            tx_shift_q <= {1'b0, tx_shift_q[`WORD_BITS-1:1]};
            tx_bit_cnt_q <= tx_bit_cnt_q + 5'h01;
            tx_gap_cnt_q <= 3'h0;
            tx_state_q <= (tx_bit_cnt_q == `TX_LAST_BIT + 5'h01) ? ST_GAP : ST_HIGH;
          end
        end
        ST_GAP: begin
          // Word gap of four bit times
          if (tx_half_tick) begin
            tx_gap_cnt_q <= tx_gap_cnt_q + 3'h1;
            if (tx_gap_cnt_q == `TX_GAP_HALF_BITS) begin
              tx_in_gap_q <= 1'b1;
              tx_state_q <= ST_SYNC;
            end
          end
        end
        default: begin
          tx_state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_tx_line_outputs_one = (tx_state_q == ST_HIGH) & tx_shift_q[0];
  assign o_tx_line_outputs_zero = (tx_state_q == ST_HIGH) & ~tx_shift_q[0];
  // idle when queue and line are empty
  assign o_tx_fifo_idle = (tx_state_q == ST_IDLE) & ~fifo_out_valid;

  // ****************************************************************
  // Receivers
  // ****************************************************************
  // loopback when option bit is low
  // receiver 2 sees ones and zeros swapped
  assign line_one = option_latch_word_q[`OPT_LOOPBACK_SELECT_N] ?
    {i_rx2_line_one, i_rx1_line_one} : {o_tx_line_outputs_zero, o_tx_line_outputs_one};
  assign line_zero = option_latch_word_q[`OPT_LOOPBACK_SELECT_N] ?
    {i_rx2_line_zero, i_rx1_line_zero} : {o_tx_line_outputs_one, o_tx_line_outputs_zero};
  // receiver 1 has priority on the bus
  assign read_on[0] = ~i_rx1_read_enable_n;
  assign read_on[1] = i_rx1_read_enable_n & ~i_rx2_read_enable_n;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_rx
      assign accept[ch] = ~option_latch_word_q[`OPT_RX1_LABEL_FILTER_EN + 3 * ch] |
        (rx_words[ch * `WORD_BITS + 9 -: 2] ==
         option_latch_word_q[`OPT_RX1_MATCH_BIT10 + 3 * ch -: 2]);
      rx_word_assembler u_rx (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_clear(soft_clear),
        .i_rx_tick(rx_tick),
        .i_line_one(line_one[ch]),
        .i_line_zero(line_zero[ch]),
        .o_word(rx_words[ch*`WORD_BITS +: `WORD_BITS]),
        .o_word_complete_event(word_event[ch])
      );

      // cleared once both bytes read, new word wins
      always @(posedge i_mclk) begin
        if (i_sys_rst || (i_clk_en && soft_clear)) begin
          ready_q[ch] <= 1'b0;
          byte1_read_q[ch] <= 1'b0;
          byte2_read_q[ch] <= 1'b0;
        end else if (i_clk_en) begin
          if (word_event[ch] && accept[ch]) begin
            ready_q[ch] <= 1'b1;
            byte1_read_q[ch] <= 1'b0;
            byte2_read_q[ch] <= 1'b0;
          end else begin
            byte1_read_q[ch] <= byte1_read_q[ch] | (read_on[ch] & ~i_byte_select);
            byte2_read_q[ch] <= byte2_read_q[ch] | (read_on[ch] & i_byte_select);
            if (byte1_read_q[ch] && byte2_read_q[ch]) begin
              ready_q[ch] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  assign o_rx1_word_ready_n = ~ready_q[0];
  assign o_rx2_word_ready_n = ~ready_q[1];

  // ****************************************************************
  // Read-back onto the bus
  // ****************************************************************
  assign o_bus_oe = read_on[0] | read_on[1];

  // byte 1 layout; byte 2 layout
  assign rd_word = read_on[0] ? rx_words[`WORD_BITS-1:0] : rx_words[2*`WORD_BITS-1:`WORD_BITS];
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_bus_out <= 16'h0000;
    end else if (i_clk_en) begin
      if (!i_byte_select) begin
        o_bus_out <= {rd_word[12:8], rd_word[30:29], rd_word[31], rd_word[0], rd_word[1],
          rd_word[2], rd_word[3], rd_word[4], rd_word[5], rd_word[6], rd_word[7]};
      end else begin
        o_bus_out <= {rd_word[13], rd_word[14], rd_word[15], rd_word[16], rd_word[17],
          rd_word[18], rd_word[19], rd_word[20], rd_word[21], rd_word[22], rd_word[23],
          rd_word[24], rd_word[25], rd_word[26], rd_word[27], rd_word[28]};
      end
    end
  end
endmodule // avionics_serial_host_port

/* File: dv/avionics_serial_host_port_assertions.sv */
// Pin-level assertions for the avionics serial host port
`timescale 1ns/1ps
`include "avionics_serial_host_port_defs.vh"
module avionics_serial_host_port_checker #(
  parameter TX_FIFO_DEPTH = 4
) (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_master_reset_n,
  input wire [15:0] i_bus_in,
  input wire o_bus_oe,
  input wire i_byte_select,
  input wire i_rx1_read_enable_n,
  input wire i_rx2_read_enable_n,
  input wire i_tx_byte2_load_n,
  input wire i_option_word_strobe,
  input wire o_rx1_word_ready_n,
  input wire o_rx2_word_ready_n,
  input wire o_tx_fifo_idle,
  input wire o_tx_fifo_full,
  input wire o_tx_line_outputs_one,
  input wire o_tx_line_outputs_zero,
  input wire o_tx_bit_clock_out
);
  // ****************
  // Shadow state
  // ****************
  reg [9:0] opt_q;
  reg strobe_q, clk_q;
  reg [1:0] settle_q, seen1_q, seen2_q;
  reg [6:0] cnt_q;
  wire clk_rise = o_tx_bit_clock_out && !clk_q;

  // Option shadow; period trusted two rises after a change
  always @(posedge i_mclk) begin
    strobe_q <= i_option_word_strobe;
    clk_q <= o_tx_bit_clock_out;
    cnt_q <= clk_rise ? 7'h01 : cnt_q + {6'h00, cnt_q != 7'h7f};
    if (i_sys_rst) begin
      opt_q <= `OPT_RESET;
      settle_q <= 2'h0;
    end else if (i_option_word_strobe && !strobe_q) begin
      opt_q <= i_bus_in[`OPT_BUS_MSB:`OPT_BUS_LSB];
      settle_q <= 2'h0;
    end else if (clk_rise && settle_q != 2'h2) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Bytes read while each flag is low
  always @(posedge i_mclk) begin
    if (i_sys_rst || o_rx1_word_ready_n) seen1_q <= 2'h0;
    else if (!i_rx1_read_enable_n) seen1_q[i_byte_select] <= 1'b1;
    if (i_sys_rst || o_rx2_word_ready_n) seen2_q <= 2'h0;
    else if (!i_rx2_read_enable_n && i_rx1_read_enable_n) seen2_q[i_byte_select] <= 1'b1;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_OE_FOLLOWS_EN:
    assert property (o_bus_oe == (!i_rx1_read_enable_n || !i_rx2_read_enable_n))
      else $error("bus drive does not follow read enables");
  AST_BITCLK_PERIOD:
    assert property (clk_rise && settle_q == 2'h2 |->
      cnt_q == (opt_q[`OPT_TX_RATE_SELECT] ? `DIV_SLOW : `DIV_FAST))
      else $error("bit clock period wrong");
  AST_ONE_ZERO_APART:
    assert property (!(o_tx_line_outputs_one && o_tx_line_outputs_zero))
      else $error("ones and zeros outputs both high");
  AST_FAST_PULSE:
    assert property ($rose(o_tx_line_outputs_one) && !opt_q[`OPT_TX_RATE_SELECT] |->
      o_tx_line_outputs_one[*5] ##1 !o_tx_line_outputs_one) else $error("pulse width wrong");
  AST_IDLE_LOW_ON_LOAD:
    assert property ($fell(i_tx_byte2_load_n) && !o_tx_fifo_full && i_master_reset_n |=>
      !o_tx_fifo_idle) else $error("idle flag stayed high after load");
  AST_NOT_IDLE_WHILE_BUSY:
    assert property (o_tx_line_outputs_one || o_tx_line_outputs_zero || o_tx_fifo_full |->
      !o_tx_fifo_idle) else $error("idle flag high while busy");
  AST_MASTER_RESET_CLEARS:
    assert property (!i_master_reset_n |=> o_rx1_word_ready_n && o_rx2_word_ready_n &&
      o_tx_fifo_idle && !o_tx_fifo_full && !o_tx_line_outputs_one)
      else $error("master reset left state behind");
  AST_RX1_HELD_TILL_READ:
    assert property ($rose(o_rx1_word_ready_n) && $past(i_master_reset_n) |-> seen1_q == 2'h3)
      else $error("receiver 1 flag cleared early");
  AST_RX2_HELD_TILL_READ:
    assert property ($rose(o_rx2_word_ready_n) && $past(i_master_reset_n) |-> seen2_q == 2'h3)
      else $error("receiver 2 flag cleared early");

  // Main scenarios reached
  cover property ($fell(o_rx1_word_ready_n));
  cover property ($fell(o_rx2_word_ready_n));
  cover property (o_tx_fifo_full);
  cover property (clk_rise && opt_q[`OPT_TX_RATE_SELECT]);
endmodule // avionics_serial_host_port_checker

bind avionics_serial_host_port avionics_serial_host_port_checker #(
  .TX_FIFO_DEPTH(TX_FIFO_DEPTH)) u_chk (.*);

/* File: dv/serial_line_sender.sv */
// Far-side line model driving one receiver's line states
`timescale 1ns/1ps
module serial_line_sender #(
  parameter HALF = 5
) (
  input wire i_mclk,
  input wire i_start,
  input wire [31:0] i_word,
  input wire i_bad,
  output reg o_line_one = 1'b0,
  output reg o_line_zero = 1'b0,
  output reg o_busy = 1'b0
);
  integer k;
  // Pulse and null per bit; the gap ends framing
  always begin
    @(posedge i_mclk);
    if (i_start) begin
      o_busy <= 1'b1;
      for (k = 0; k < 32; k = k + 1) begin
        o_line_one <= i_word[k] || (i_bad && k == 4);
        o_line_zero <= !i_word[k] || (i_bad && k == 4);
        repeat (HALF) @(posedge i_mclk);
        o_line_one <= 1'b0;
        o_line_zero <= 1'b0;
        repeat (HALF) @(posedge i_mclk);
      end
      repeat (8 * HALF) @(posedge i_mclk);
      o_busy <= 1'b0;
    end
  end
endmodule // serial_line_sender

/* File: dv/tb_avionics_serial_host_port.sv */
// Self-checking bench for the avionics serial host port
`timescale 1ns/1ps
module tb_avionics_serial_host_port;
  localparam int DEPTH = 4;
  typedef struct {logic [9:0] opt; logic [15:0] b1; logic [15:0] b2; logic r1; logic r2;} row_t;
  // Rows: options, bytes, expected flags
  row_t rows [5] = '{'{10'h000, 16'hA5C3, 16'h1234, 1'b1, 1'b1},
    '{10'h080, 16'h0F0F, 16'hFFFF, 1'b1, 1'b1}, '{10'h03E, 16'h1800, 16'hAAAA, 1'b1, 1'b0},
    '{10'h012, 16'h1800, 16'h5555, 1'b0, 1'b1}, '{10'h300, 16'h8001, 16'h0001, 1'b1, 1'b1}};
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1, i_master_reset_n = 1'b1;
  logic [15:0] i_bus_in = 16'h0000;
  logic i_byte_select = 1'b0, i_rx1_read_enable_n = 1'b1, i_rx2_read_enable_n = 1'b1;
  logic i_tx_byte1_load_n = 1'b1, i_tx_byte2_load_n = 1'b1, i_option_word_strobe = 1'b0;
  logic i_tx_enable_transmit = 1'b0, i_rx2_line_one = 1'b0, i_rx2_line_zero = 1'b0;
  logic send = 1'b0, bad = 1'b0, last = 1'b0;
  logic [31:0] word = 32'h0000_0000;
  wire i_rx1_line_one, i_rx1_line_zero, busy, o_bus_oe, o_tx_bit_clock_out;
  wire [15:0] o_bus_out;
  wire o_rx1_word_ready_n, o_rx2_word_ready_n, o_tx_fifo_idle, o_tx_fifo_full;
  wire o_tx_line_outputs_one, o_tx_line_outputs_zero;
  int mismatches = 0, tests_run = 0, cycles = 0, k, n;

  avionics_serial_host_port #(.TX_FIFO_DEPTH(DEPTH)) dut (.*);
  serial_line_sender #(.HALF(5)) far (.i_mclk, .i_start(send), .i_word(word), .i_bad(bad),
    .o_line_one(i_rx1_line_one), .o_line_zero(i_rx1_line_zero), .o_busy(busy));

  // Clock; hang guard
  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic opt_wr(input logic [9:0] v);
    @(negedge i_mclk);
    i_bus_in = {1'b0, v, 5'h00};
    i_option_word_strobe = 1'b1;
    @(negedge i_mclk);
    i_option_word_strobe = 1'b0;
  endtask
  task automatic load(input logic [15:0] b1, input logic [15:0] b2);
    @(negedge i_mclk);
    i_bus_in = b1;
    i_tx_byte1_load_n = 1'b0;
    @(negedge i_mclk);
    i_tx_byte1_load_n = 1'b1;
    @(negedge i_mclk);
    i_bus_in = b2;
    i_tx_byte2_load_n = 1'b0;
    @(negedge i_mclk);
    i_tx_byte2_load_n = 1'b1;
  endtask
  // Receiver 1 reads hold both enables low; receiver 1 must win
  task automatic rd(input logic rx2, input logic sel, input logic [15:0] exp);
    @(negedge i_mclk);
    i_rx1_read_enable_n = rx2;
    i_rx2_read_enable_n = 1'b0;
    i_byte_select = sel;
    repeat (2) @(negedge i_mclk);
    chk16(o_bus_out, exp);
    i_rx1_read_enable_n = 1'b1;
    i_rx2_read_enable_n = 1'b1;
  endtask
  function automatic logic rdy(input logic rx2);
    return rx2 ? o_rx2_word_ready_n : o_rx1_word_ready_n;
  endfunction
  // Byte 2 first: the flag must outlast the first read
  task automatic rx_check(input logic rx2, want, par, input logic [15:0] b1, b2);
    logic [15:0] m;
    m = {16{rx2}};
    chk1(rdy(rx2), !want);
    if (want) begin
      rd(rx2, 1'b1, b2 ^ m);
      chk1(rdy(rx2), 1'b0);
      rd(rx2, 1'b0, {b1[15:9] ^ m[15:9], par, b1[7:0] ^ m[7:0]});
      repeat (2) @(negedge i_mclk);
      chk1(rdy(rx2), 1'b1);
    end
  endtask
  task automatic wait_idle(input int lim);
    repeat (2) @(negedge i_mclk);
    for (n = 0; n < lim && o_tx_fifo_idle !== 1'b1; n++) @(negedge i_mclk);
    chk1(o_tx_fifo_idle, 1'b1);
    repeat (4) @(negedge i_mclk);
  endtask
  task automatic send_word();
    @(negedge i_mclk);
    send = 1'b1;
    @(negedge i_mclk);
    send = 1'b0;
    for (n = 0; n < 2000 && busy; n++) @(negedge i_mclk);
  endtask
  // Serial order of a loaded pair of bytes, odd parity in bit 32
  function automatic logic [31:0] to_serial(input logic [15:0] b1, input logic [15:0] b2);
    logic [31:0] w;
    for (int i = 0; i < 8; i++) w[i] = b1[7 - i];
    for (int i = 0; i < 5; i++) w[8 + i] = b1[11 + i];
    for (int i = 0; i < 16; i++) w[13 + i] = b2[15 - i];
    w[29] = b1[9];
    w[30] = b1[10];
    w[31] = ~^w[30:0];
    return w;
  endfunction
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    i_tx_enable_transmit = 1'b1;
    foreach (rows[r]) begin
      opt_wr(rows[r].opt);
      load(rows[r].b1, rows[r].b2);
      wait_idle(rows[r].opt[8] ? 4000 : 800);
      rx_check(1'b0, rows[r].r1, rows[r].opt[7], rows[r].b1, rows[r].b2);
      rx_check(1'b1, rows[r].r2, rows[r].opt[7], rows[r].b1, rows[r].b2);
      $display("row %0d done", r);
    end
    // Line inputs: bad word dropped, next taken
    opt_wr(10'h101);
    word = to_serial(16'h3C5A, 16'hBEEF);
    bad = 1'b1;
    send_word();
    rx_check(1'b0, 1'b0, 1'b0, 16'h3C5A, 16'hBEEF);
    bad = 1'b0;
    send_word();
    rx_check(1'b0, 1'b1, 1'b0, 16'h3C5A, 16'hBEEF);
    $display("line input test done");
    // Master reset with a flagged word and a held word
    i_tx_enable_transmit = 1'b0;
    send_word();
    load(16'h0001, 16'h0002);
    repeat (2) @(negedge i_mclk);
    chk1(o_rx1_word_ready_n, 1'b0);
    chk1(o_tx_fifo_idle, 1'b0);
    i_master_reset_n = 1'b0;
    @(negedge i_mclk);
    i_master_reset_n = 1'b1;
    @(negedge i_mclk);
    chk1(o_rx1_word_ready_n, 1'b1);
    chk1(o_tx_fifo_idle, 1'b1);
    $display("master reset test done");
    // Overfill, then count bit pulses
    opt_wr(10'h001);
    for (k = 0; k <= DEPTH; k++) load(16'h00FF, 16'(k));
    chk1(o_tx_fifo_full, 1'b1);
    i_tx_enable_transmit = 1'b1;
    n = 0;
    for (k = 0; k < 3000 && o_tx_fifo_idle !== 1'b1; k++) begin
      @(negedge i_mclk);
      if ((o_tx_line_outputs_one || o_tx_line_outputs_zero) && !last) n++;
      last = o_tx_line_outputs_one || o_tx_line_outputs_zero;
    end
    chk16(16'(n), 16'(DEPTH * 32));
    $display("buffer test done");
    conclude();
  end
endmodule // tb_avionics_serial_host_port
